//--- include/video_dac_pkg.sv
// =============================================================
// video dac input latch package
// =============================================================
// constants and selection codes shared by the latch and its testbench
// assumes nothing beyond a SystemVerilog compiler
package video_dac_pkg;
    localparam int COLOR_WIDTH = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CTRL_WIDTH = 3;
    // position of each control inside a fifo word, below the pixels
    localparam int POS_BLANK = 0;
    localparam int POS_SYNC = 1;
    localparam int POS_WHITE = 2;
    // value driven while blanked or forced white
    localparam logic [7:0] LEVEL_BLANK = 8'h00;
    localparam logic [7:0] LEVEL_WHITE = 8'hFF;
    // output selection per channel
    typedef enum logic [1:0] {SEL_BLANK, SEL_WHITE, SEL_DATA} level_sel_t;
endpackage

//--- rtl/video_dac_latch.sv
// =============================================================
// pixel input latch for a triple 8-bit video converter
// =============================================================
// holds a small fifo and the pixel input latch
// assumes the pixel source is synchronous to mclk
//
// Behaviour
// - blank low drives all three colour outputs blank
// - blank low ignores pixels and white
// - sync low turns off sync current
// - pixels and controls captured together on each edge that takes a fifo word
// - white high forces white unless blanked
// - bit zero is channel lsb
// - each channel held in own register
`timescale 1ns/1ps

module pixel_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("fifo depth must be a power of two, at least 2");
        end
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;
    // handshake and head of queue
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    // pointer update
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    property p_refuse;
        @(posedge mclk) disable iff (reset)
        (in_valid && full) |=> $stable(wr_ptr);
    endproperty
    a_refuse: assert property (p_refuse) else $error("word taken while full");
endmodule

module video_dac_latch
    import video_dac_pkg::*;
#(
    parameter int CW = COLOR_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // pixel source side
    input wire logic pixel_valid,
    output logic pixel_ready,
    input wire logic [CW-1:0] red_pixel,
    input wire logic [CW-1:0] green_pixel,
    input wire logic [CW-1:0] blue_pixel,
    input wire logic blank_n,
    input wire logic sync_n,
    input wire logic ref_white,
    // converter side
    input wire logic dac_ready,
    output logic out_valid,
    output logic [CW-1:0] red_current_out,
    output logic [CW-1:0] green_current_out,
    output logic [CW-1:0] blue_current_out,
    output logic sync_current_out
);
    localparam int W = 3 * CW + CTRL_WIDTH;
    initial begin
        if (CW != COLOR_WIDTH) begin
            $error("channel width must be 8");
        end
    end
    logic fifo_valid;
    logic [W-1:0] fifo_data;
    logic [W-1:0] word_in;
    assign word_in = {red_pixel, green_pixel, blue_pixel, ref_white, sync_n, blank_n};
    pixel_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
        .mclk(mclk),
        .reset(reset),
        .in_valid(pixel_valid),
        .in_ready(pixel_ready),
        .in_data(word_in),
        .out_valid(fifo_valid),
        .out_ready(dac_ready),
        .out_data(fifo_data)
    );
    wire take = fifo_valid && dac_ready;
    wire q_blank_n = fifo_data[POS_BLANK];
    wire q_sync_n = fifo_data[POS_SYNC];
    wire q_white = fifo_data[POS_WHITE];
    // lsb at bit zero of each channel field
    wire [CW-1:0] q_blue = fifo_data[CTRL_WIDTH +: CW];
    wire [CW-1:0] q_green = fifo_data[CTRL_WIDTH + CW +: CW];
    wire [CW-1:0] q_red = fifo_data[CTRL_WIDTH + 2 * CW +: CW];
    level_sel_t next_sel;
    assign next_sel = !q_blank_n ? SEL_BLANK : (q_white ? SEL_WHITE : SEL_DATA);
    level_sel_t sel;
    logic [CW-1:0] red_q;
    logic [CW-1:0] green_q;
    logic [CW-1:0] blue_q;
    logic sync_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            sel <= SEL_BLANK;
            red_q <= '0;
            green_q <= '0;
            blue_q <= '0;
            sync_q <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= take;
            if (take) begin
                sel <= next_sel;
                red_q <= q_red;
                green_q <= q_green;
                blue_q <= q_blue;
                sync_q <= q_sync_n;
            end
        end
    end
    function automatic logic [CW-1:0] level(input level_sel_t s, input logic [CW-1:0] d);
        case (s)
            SEL_BLANK: level = LEVEL_BLANK;
            SEL_WHITE: level = LEVEL_WHITE;
            SEL_DATA: level = d;
            default: level = LEVEL_BLANK;
        endcase
    endfunction
    // per channel level
    assign red_current_out = level(sel, red_q);
    assign green_current_out = level(sel, green_q);
    assign blue_current_out = level(sel, blue_q);
    // sync current follows latched sync; not overridden
    assign sync_current_out = sync_q;

    // =============================================================
    // assertions
    property p_blank;
        @(posedge mclk) disable iff (reset)
        (take && !q_blank_n) |=> (red_current_out == LEVEL_BLANK && blue_current_out == LEVEL_BLANK
            && green_current_out == LEVEL_BLANK);
    endproperty
    a_blank: assert property (p_blank) else $error("blank not applied");
    property p_blank_over_white;
        @(posedge mclk) disable iff (reset)
        (take && !q_blank_n && q_white) |=> (red_current_out != LEVEL_WHITE);
    endproperty
    a_blank_over_white: assert property (p_blank_over_white) else $error("white beat blank");
    property p_sync;
        @(posedge mclk) disable iff (reset)
        take |=> (sync_current_out == $past(q_sync_n));
    endproperty
    a_sync: assert property (p_sync) else $error("sync current wrong");
    property p_white;
        @(posedge mclk) disable iff (reset)
        (take && q_blank_n && q_white) |=> (red_current_out == LEVEL_WHITE && green_current_out == LEVEL_WHITE
            && blue_current_out == LEVEL_WHITE);
    endproperty
    a_white: assert property (p_white) else $error("white not forced");
    property p_data;
        @(posedge mclk) disable iff (reset)
        (take && q_blank_n && !q_white) |=> (red_current_out == $past(q_red) && green_current_out == $past(q_green)
            && blue_current_out == $past(q_blue));
    endproperty
    a_data: assert property (p_data) else $error("data not passed");
    property p_hold;
        @(posedge mclk) disable iff (reset)
        (!take) |=> $stable(red_current_out) && $stable(green_current_out)
            && $stable(blue_current_out) && $stable(sync_current_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved without capture");
    property p_valid;
        @(posedge mclk) disable iff (reset)
        take |=> out_valid;
    endproperty
    a_valid: assert property (p_valid) else $error("valid missing");
    property p_quiet;
        @(posedge mclk) disable iff (reset)
        (!take) |=> !out_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("valid without a word");
    property p_lsb;
        @(posedge mclk) disable iff (reset)
        (take && q_blank_n && !q_white) |=> (blue_current_out[0] == $past(fifo_data[CTRL_WIDTH]));
    endproperty
    a_lsb: assert property (p_lsb) else $error("lsb misplaced");
endmodule

//--- verification/pixel_source_model.sv
// =============================================================
// pixel source model
// =============================================================
// stands in for the frame buffer feeding the latch
// assumes words are driven at the falling edge of mclk
`timescale 1ns/1ps
module pixel_source_model (
    // clock
    input wire logic mclk,
    // handshake
    output logic pixel_valid,
    input wire logic pixel_ready,
    // pixel word
    output logic [7:0] red_pixel,
    output logic [7:0] green_pixel,
    output logic [7:0] blue_pixel,
    output logic blank_n,
    output logic sync_n,
    output logic ref_white
);
    initial begin
        pixel_valid = 1'b0;
        {ref_white, sync_n, blank_n, blue_pixel, green_pixel, red_pixel} = 27'h0000000;
    end
    // offer one word, hold it until an edge with ready high
    task automatic send(input logic [26:0] w);
        @(negedge mclk);
        {ref_white, sync_n, blank_n, blue_pixel, green_pixel, red_pixel} = w;
        pixel_valid = 1'b1;
        // ready only moves at rising edges, so look at it mid-cycle
        while (pixel_ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
    endtask
    // release: lines no longer show the last word
    task automatic idle();
        @(negedge mclk);
        pixel_valid = 1'b0;
        {ref_white, sync_n, blank_n, blue_pixel, green_pixel, red_pixel} =
            ~{ref_white, sync_n, blank_n, blue_pixel, green_pixel, red_pixel};
    endtask
endmodule

//--- verification/test_video_dac_latch.sv
// =============================================================
// testbench for the pixel input latch
// =============================================================
// self-checking; notes expected levels in a queue, a monitor compares
// assumes a 10 MHz mclk and the source model beside it
`timescale 1ns/1ps
module test_video_dac_latch;
    import video_dac_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic dac_ready = 1'b1;
    logic rand_drain = 1'b0;
    logic pixel_valid, pixel_ready, blank_n, sync_n, ref_white, out_valid, sync_current_out;
    logic [7:0] red_pixel, green_pixel, blue_pixel, red_current_out, green_current_out, blue_current_out;
    logic [24:0] exp_q[$];
    logic [26:0] w;
    int num_errors = 0;
    int compares = 0;
    integer seed = 91;
    logic [26:0] table_w[5] = '{27'h6A5C33C, 27'h0123456, 27'h7000000, 27'h3018001, 27'h3000000};

    always #50 mclk = ~mclk;

    pixel_source_model pixel_source_model_i (.mclk(mclk), .pixel_valid(pixel_valid),
        .pixel_ready(pixel_ready), .red_pixel(red_pixel), .green_pixel(green_pixel),
        .blue_pixel(blue_pixel), .blank_n(blank_n), .sync_n(sync_n), .ref_white(ref_white));
    video_dac_latch video_dac_latch_i (.mclk(mclk), .reset(reset), .pixel_valid(pixel_valid),
        .pixel_ready(pixel_ready), .red_pixel(red_pixel), .green_pixel(green_pixel),
        .blue_pixel(blue_pixel), .blank_n(blank_n), .sync_n(sync_n), .ref_white(ref_white),
        .dac_ready(dac_ready), .out_valid(out_valid), .red_current_out(red_current_out),
        .green_current_out(green_current_out), .blue_current_out(blue_current_out),
        .sync_current_out(sync_current_out));

    // expected {sync, blue, green, red}: blank over white over data
    function automatic logic [24:0] level_of(input logic [26:0] v);
        if (!v[24]) return {v[25], {3{LEVEL_BLANK}}};
        if (v[26]) return {v[25], {3{LEVEL_WHITE}}};
        return {v[25], v[23:0]};
    endfunction
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [26:0] v);
        exp_q.push_back(level_of(v));
        pixel_source_model_i.send(v);
    endtask
    task automatic drain();
        for (int n = 0; n < 300 && exp_q.size() != 0; n++) @(negedge mclk);
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("FAIL %0t words never came out", $time);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // monitor: each output word against the oldest note
    always @(negedge mclk) begin
        if (out_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(25'h1FFFFFF, 25'h0);
            else chk({sync_current_out, blue_current_out, green_current_out, red_current_out},
                     exp_q.pop_front());
        end
    end
    // random converter stalls
    always @(negedge mclk) if (rand_drain) dac_ready <= $random(seed);
    // watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        $display("FAIL %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        chk({24'h0, pixel_ready}, 25'h1);
        // blank, sync, white, lsb and black cases back to back
        foreach (table_w[i]) push(table_w[i]);
        pixel_source_model_i.idle();
        drain();
        $display("test directed done");
        // fill until refused, then drain
        dac_ready = 1'b0;
        for (int i = 0; i < 4; i++) push({3'h3, 24'(i * 3 + 1)});
        // fifth word waits while full, taken once one leaves
        fork
            push({3'h3, 24'h00ABCD});
            begin
                repeat (3) @(negedge mclk);
                chk({24'h0, pixel_ready}, 25'h0);
                dac_ready = 1'b1;
            end
        join
        pixel_source_model_i.idle();
        drain();
        $display("test fill done");
        // random words under random stalls
        rand_drain = 1'b1;
        for (int i = 0; i < 40; i++) begin
            w = 27'($random(seed));
            if (!w[25]) w[24] = 1'b0;
            push(w);
        end
        pixel_source_model_i.idle();
        rand_drain = 1'b0;
        @(negedge mclk);
        dac_ready = 1'b1;
        drain();
        $display("test random done");
        // reset while a word waits: fifo and outputs cleared
        dac_ready = 1'b0;
        push({3'h3, 24'h5A5A5A});
        pixel_source_model_i.idle();
        reset = 1'b1;
        exp_q.delete();
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        dac_ready = 1'b1;
        chk({sync_current_out, blue_current_out, green_current_out, red_current_out}, 25'h0);
        repeat (3) @(negedge mclk);
        chk({23'h0, out_valid, pixel_ready}, 25'h1);
        push({3'h3, 24'h123456});
        pixel_source_model_i.idle();
        drain();
        $display("test reset done");
        tally_and_finish();
    end
endmodule
